// ===== hdl/lphc_top.sv
// correction control stage of the per-dot corrected led print head
`timescale 1ns/1ps
`include "lphc_map.svh"

// Summary of operation
// (RQ1) After reset, and whenever the latch control is low, the head runs in normal print mode.
// (RQ2) In normal mode each shift clock rise moves the four data lines into the four driver chains.
// (RQ3) A high pulse on the latch control copies the shift chains into the driver latches.
// (RQ4) A latched dot lights only while its group's active-low fire strobe is low.
// (RQ5) With the latch control held high, four bits of data line zero are taken on shift clock falls.
// (RQ6) The four bits are decoded and correction mode starts at the fifth shift clock fall.
// (RQ7) Correction mode lasts while the latch control stays high and ends when it goes low.
// (RQ8) Every dot owns a four-bit code picking one of sixteen current steps.
// (RQ9) Code 0 is no change, 1-7 add 2-14 percent, 8 adds 16, 15 down to 9 take 2-14 percent.
// (RQ10) The correction changes the dot current, never its on-time.
// (RQ11) Pin signals pass through this stage to the drivers with the same print sequence.
// (RQ12) Even dots sit on one driver side and odd dots on the other, each at half the pitch.
// (RQ13) Per-dot codes are kept in on-chip storage here and fed to the drivers.
// (RQ14) The host keeps the latch control high until the last correction word has been shifted.
module lphc_top #(
  parameter int DOTS = 64
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // head pins from the host
  input wire lphc_pkg::lphc_pins_t i_pins,
  // register port
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // pin copy toward the drivers
  output lphc_pkg::lphc_pins_t o_fwd_pins,
  // dot drive, side a holds even dots and side b odd dots
  output logic [DOTS/2-1:0] o_side_a_on,
  output logic [DOTS/2-1:0] o_side_b_on,
  output logic [DOTS/2-1:0][7:0] o_side_a_current,
  output logic [DOTS/2-1:0][7:0] o_side_b_current,
  // mode
  output logic o_corr_mode
);

  localparam int CHAIN = DOTS / 4;
  localparam int AW = $clog2(DOTS);

  lphc_pkg::lphc_bus_req_t req;
  assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

  // three-stage capture; a change counts once stages two and three agree
  lphc_pkg::lphc_pins_t sync1_reg;
  lphc_pkg::lphc_pins_t sync2_reg;
  lphc_pkg::lphc_pins_t sync3_reg;
  lphc_pkg::lphc_pins_t filt_reg;
  lphc_pkg::lphc_pins_t filt_next;
  lphc_pkg::lphc_pins_t prev_reg;

  assign filt_next = (sync2_reg & ~(sync2_reg ^ sync3_reg)) | (filt_reg & (sync2_reg ^ sync3_reg));

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
      filt_reg <= '0;
      prev_reg <= '0;
    end else begin
      sync1_reg <= i_pins;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      filt_reg <= filt_next;
      prev_reg <= filt_reg;
    end
  end

  logic clk_rise;
  logic clk_fall;
  logic latch_rise;
  logic latch_fall;

  assign clk_rise = filt_reg.print_shift_clock & ~prev_reg.print_shift_clock;
  assign clk_fall = ~filt_reg.print_shift_clock & prev_reg.print_shift_clock;
  assign latch_rise = filt_reg.data_latch_ctl & ~prev_reg.data_latch_ctl;
  assign latch_fall = ~filt_reg.data_latch_ctl & prev_reg.data_latch_ctl;

  // pins toward the drivers keep their order and spacing
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_fwd_pins <= '0;
    end else begin
      o_fwd_pins <= filt_reg; // (RQ11)
    end
  end

  // mode control
  lphc_pkg::lphc_state_t state_reg;
  logic [2:0] sel_cnt_reg;
  logic [3:0] sel_bits_reg;
  logic [3:0] mode_code_reg;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= lphc_pkg::LPHC_NORMAL; // (RQ1)
    end else begin
      case (state_reg)
        lphc_pkg::LPHC_NORMAL: begin
          if (latch_rise) begin
            state_reg <= lphc_pkg::LPHC_SELECT; // (RQ5)
          end
        end
        lphc_pkg::LPHC_SELECT: begin
          if (latch_fall) begin
            state_reg <= lphc_pkg::LPHC_NORMAL; // (RQ1)
          end else if (clk_fall && sel_cnt_reg == `LPHC_SEL_LEN && sel_bits_reg == `LPHC_CORR_CODE) begin
            state_reg <= lphc_pkg::LPHC_CORRECT; // (RQ6)
          end
        end
        lphc_pkg::LPHC_CORRECT: begin
          if (latch_fall) begin
            state_reg <= lphc_pkg::LPHC_NORMAL; // (RQ7)
          end
        end
        default: begin
          state_reg <= lphc_pkg::LPHC_NORMAL;
        end
      endcase
    end
  end

  // select bits arrive first-bit-msb on data line zero
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sel_cnt_reg <= 3'h0;
      sel_bits_reg <= 4'h0;
      mode_code_reg <= 4'h0;
    end else if (state_reg != lphc_pkg::LPHC_SELECT) begin
      sel_cnt_reg <= 3'h0;
    end else if (clk_fall) begin
      if (sel_cnt_reg < `LPHC_SEL_LEN) begin
        sel_bits_reg <= {sel_bits_reg[2:0], filt_reg.print_data_line[0]}; // (RQ5)
        sel_cnt_reg <= sel_cnt_reg + 3'h1;
      end else if (sel_cnt_reg == `LPHC_SEL_LEN) begin
        mode_code_reg <= sel_bits_reg; // (RQ6)
        sel_cnt_reg <= sel_cnt_reg + 3'h1;
      end
    end
  end

  assign o_corr_mode = (state_reg == lphc_pkg::LPHC_CORRECT);

  // driver shift chains and latches
  logic [DOTS-1:0] shift_reg;
  logic [DOTS-1:0] latch_reg;

  // chain k holds dots k*CHAIN .. k*CHAIN+CHAIN-1, newest bit at the top
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      shift_reg <= '0;
    end else if (state_reg == lphc_pkg::LPHC_NORMAL && clk_rise) begin
      for (int k = 0; k < 4; k++) begin
        for (int p = 0; p < CHAIN - 1; p++) begin
          shift_reg[k*CHAIN+p] <= shift_reg[k*CHAIN+p+1]; // (RQ2)
        end
        shift_reg[k*CHAIN+CHAIN-1] <= filt_reg.print_data_line[k]; // (RQ2)
      end
    end
  end

  // latching on the rising side of the pulse also opens mode select;
  // a pulse with no clock in it never reaches the fifth fall
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      latch_reg <= '0;
    end else if (state_reg == lphc_pkg::LPHC_NORMAL && latch_rise) begin
      latch_reg <= shift_reg; // (RQ3)
    end
  end

  // correction code storage, not cleared by reset
  logic [3:0] corr_mem [DOTS];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] mem_addr_reg;
  logic [1:0] ctrl_reg;
  logic bus_mem_wr;

  assign bus_mem_wr = req.wr && req.addr == `LPHC_REG_MEM_DATA && !ctrl_reg[`LPHC_CTRL_LOCK];

  // one code per shift rise, lines 3..0 as b3..b0
  always_ff @(posedge i_clk) begin
    if (o_corr_mode && clk_rise) begin
      corr_mem[wr_ptr_reg] <= filt_reg.print_data_line; // (RQ13)
    end else if (bus_mem_wr) begin
      corr_mem[mem_addr_reg] <= req.wdata[3:0]; // (RQ13)
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr_reg <= '0;
    end else if (!o_corr_mode) begin
      wr_ptr_reg <= '0;
    end else if (clk_rise) begin
      wr_ptr_reg <= AW'(wr_ptr_reg + 1'b1); // (RQ14)
    end
  end

  // fire and drive
  logic [DOTS-1:0] fire_now;
  logic [DOTS-1:0] dot_on;
  logic [DOTS-1:0][7:0] dot_current;

  always_comb begin
    for (int d = 0; d < DOTS; d++) begin
      fire_now[d] = latch_reg[d] & ~filt_reg.led_fire_strobe_n[d / CHAIN]; // (RQ4)
    end
  end

  genvar g;
  generate
    for (g = 0; g < DOTS; g++) begin : g_dot
      lphc_dot_drive u_drive (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_lit(fire_now[g]),
        .i_apply(ctrl_reg[`LPHC_CTRL_APPLY]),
        .i_code(corr_mem[g]),
        .o_on(dot_on[g]),
        .o_current(dot_current[g])
      );
    end
  endgenerate

  always_comb begin
    for (int h = 0; h < DOTS / 2; h++) begin
      o_side_a_on[h] = dot_on[2*h]; // (RQ12)
      o_side_b_on[h] = dot_on[2*h+1]; // (RQ12)
      o_side_a_current[h] = dot_current[2*h];
      o_side_b_current[h] = dot_current[2*h+1];
    end
  end

  // activity counters
  logic [15:0] line_cnt_reg;
  logic [15:0] corr_cnt_reg;
  logic [15:0] bad_cnt_reg;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      line_cnt_reg <= 16'h0000;
      corr_cnt_reg <= 16'h0000;
      bad_cnt_reg <= 16'h0000;
    end else begin
      if (state_reg == lphc_pkg::LPHC_NORMAL && latch_rise) begin
        line_cnt_reg <= line_cnt_reg + 16'h0001;
      end
      if (o_corr_mode && clk_rise) begin
        corr_cnt_reg <= corr_cnt_reg + 16'h0001;
      end
      if (state_reg == lphc_pkg::LPHC_SELECT && clk_fall && sel_cnt_reg == `LPHC_SEL_LEN
          && sel_bits_reg != `LPHC_CORR_CODE) begin
        bad_cnt_reg <= bad_cnt_reg + 16'h0001;
      end
    end
  end

  // register writes
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_reg <= `LPHC_CTRL_RESET;
      mem_addr_reg <= '0;
    end else if (req.wr) begin
      case (req.addr)
        `LPHC_REG_CTRL: begin
          ctrl_reg <= req.wdata[1:0];
        end
        `LPHC_REG_MEM_ADDR: begin
          mem_addr_reg <= req.wdata[AW-1:0];
        end
        default: begin
          mem_addr_reg <= mem_addr_reg;
        end
      endcase
    end
  end

  // register reads, data stands one cycle after the strobe only
  logic [31:0] rd_next;

  always_comb begin
    rd_next = 32'h0000_0000;
    case (req.addr)
      `LPHC_REG_CTRL: begin
        rd_next[1:0] = ctrl_reg;
      end
      `LPHC_REG_STATUS: begin
        rd_next[`LPHC_ST_CORR] = o_corr_mode;
        rd_next[`LPHC_ST_SEL] = (state_reg == lphc_pkg::LPHC_SELECT);
        rd_next[`LPHC_ST_CODE_MSB:`LPHC_ST_CODE_LSB] = mode_code_reg;
      end
      `LPHC_REG_MEM_ADDR: begin
        rd_next[AW-1:0] = mem_addr_reg;
      end
      `LPHC_REG_MEM_DATA: begin
        rd_next[3:0] = corr_mem[mem_addr_reg];
      end
      `LPHC_REG_LINE_CNT: begin
        rd_next[15:0] = line_cnt_reg;
      end
      `LPHC_REG_CORR_CNT: begin
        rd_next[15:0] = corr_cnt_reg;
      end
      `LPHC_REG_BAD_CNT: begin
        rd_next[15:0] = bad_cnt_reg;
      end
      default: begin
        rd_next = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 32'h0000_0000;
    end else if (req.rd) begin
      o_rdata <= rd_next;
    end else begin
      o_rdata <= 32'h0000_0000;
    end
  end

endmodule

// ===== hdl/lphc_map.svh
// register offsets, field positions, reset values and codes of the correction head
`ifndef LPHC_MAP_SVH
`define LPHC_MAP_SVH

`define LPHC_REG_CTRL 8'h00
`define LPHC_REG_STATUS 8'h04
`define LPHC_REG_MEM_ADDR 8'h08
`define LPHC_REG_MEM_DATA 8'h0c
`define LPHC_REG_LINE_CNT 8'h10
`define LPHC_REG_CORR_CNT 8'h14
`define LPHC_REG_BAD_CNT 8'h18

`define LPHC_CTRL_APPLY 0
`define LPHC_CTRL_LOCK 1
`define LPHC_CTRL_RESET 2'h1

`define LPHC_ST_CORR 0
`define LPHC_ST_SEL 1
`define LPHC_ST_CODE_LSB 4
`define LPHC_ST_CODE_MSB 7

`define LPHC_SEL_LEN 3'h4
`define LPHC_CORR_CODE 4'ha
`define LPHC_FULL_CODE 4'h8
`define LPHC_MAX_PCT 8'h10
`define LPHC_STD_PCT 8'h64

`endif

// ===== hdl/lphc_pkg.sv
// types shared by the correction head logic
package lphc_pkg;

  typedef struct packed {
    logic print_shift_clock;
    logic data_latch_ctl;
    logic [3:0] print_data_line;
    logic [3:0] led_fire_strobe_n;
  } lphc_pins_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } lphc_bus_req_t;

  typedef enum logic [2:0] {
    LPHC_NORMAL = 3'b001,
    LPHC_SELECT = 3'b010,
    LPHC_CORRECT = 3'b100
  } lphc_state_t;

endpackage

// ===== hdl/lphc_dot_drive.sv
// per-dot drive stage: on/off follows the strobe, current follows the correction code
`timescale 1ns/1ps
`include "lphc_map.svh"

module lphc_dot_drive (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // dot control
  input wire logic i_lit,
  input wire logic i_apply,
  input wire logic [3:0] i_code,
  // dot drive
  output logic o_on,
  output logic [7:0] o_current
);

  function automatic logic signed [7:0] code_to_pct(input logic [3:0] code);
    logic signed [7:0] s;
    s = {{4{code[3]}}, code};
    if (code == `LPHC_FULL_CODE) begin
      return `LPHC_MAX_PCT;
    end
    return s <<< 1;
  endfunction

  logic signed [7:0] pct;

  assign pct = i_apply ? code_to_pct(i_code) : 8'sh00;

  // on-time is untouched; only the current level moves
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_on <= 1'b0;
      o_current <= 8'h00;
    end else begin
      o_on <= i_lit; // (RQ10)
      o_current <= i_lit ? 8'(`LPHC_STD_PCT + pct) : 8'h00; // (RQ8) (RQ9) (RQ10)
    end
  end

endmodule

// ===== tb/lphc_top_sva.sv
// port checker for the correction head stage
`timescale 1ns/1ps
module lphc_top_chk #(
  parameter int DOTS = 64
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire lphc_pkg::lphc_pins_t i_pins,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  input wire lphc_pkg::lphc_pins_t o_fwd_pins,
  input wire logic [DOTS/2-1:0] o_side_a_on,
  input wire logic [DOTS/2-1:0] o_side_b_on,
  input wire logic [DOTS/2-1:0][7:0] o_side_a_current,
  input wire logic [DOTS/2-1:0][7:0] o_side_b_current,
  input wire logic o_corr_mode
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  logic [3:0] up_reg;
  // pin pipeline still holds reset values just after release
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      up_reg <= 4'h0;
    end else if (up_reg != 4'hf) begin
      up_reg <= up_reg + 4'h1;
    end
  end
  a_rdata_idle: assert property (!i_rd |=> o_rdata == 32'h0000_0000)
    else $error("read data not zero outside a read answer");
  a_pins_forward: assert property ((up_reg == 4'hf && $stable(i_pins)) [*6] |-> o_fwd_pins == i_pins)
    else $error("forwarded pins differ from settled host pins");
  a_corr_start: assert property ($rose(o_corr_mode) |-> o_fwd_pins.data_latch_ctl && !o_fwd_pins.print_shift_clock)
    else $error("correction mode began without latch high and clock fall");
  a_corr_end: assert property ($fell(o_fwd_pins.data_latch_ctl) |-> ##[0:3] !o_corr_mode)
    else $error("correction mode outlived latch control");
  a_corr_hold: assert property (o_corr_mode && o_fwd_pins.data_latch_ctl ##1 o_fwd_pins.data_latch_ctl |-> o_corr_mode)
    else $error("correction mode dropped while latch control high");
  a_normal_low: assert property ((!o_fwd_pins.data_latch_ctl) [*4] |-> !o_corr_mode)
    else $error("correction mode with latch control low");
  a_dark_idle: assert property ((&o_fwd_pins.led_fire_strobe_n) [*3] |-> !(|o_side_a_on) && !(|o_side_b_on))
    else $error("dot lit with every strobe released");
  // forwarded pins and dot outputs come from the same filtered sample
  a_lit_strobe: assert property (o_side_a_on[0] |-> !o_fwd_pins.led_fire_strobe_n[0])
    else $error("first dot lit without its strobe");
  a_dark_current: assert property (!o_side_a_on[0] |-> o_side_a_current[0] == 8'h00)
    else $error("dark dot carries current");
  a_lit_current: assert property (o_side_b_on[0] |->
    o_side_b_current[0] inside {[8'h56:8'h74]} && !o_side_b_current[0][0])
    else $error("lit dot current off the step grid");
  c_corr_on: cover property ($rose(o_corr_mode));
  c_corr_off: cover property ($fell(o_corr_mode));
  c_dot_lit: cover property (o_side_b_on[0]);
endmodule

bind lphc_top lphc_top_chk #(.DOTS(DOTS)) chk (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_pins(i_pins),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_fwd_pins(o_fwd_pins),
  .o_side_a_on(o_side_a_on), .o_side_b_on(o_side_b_on), .o_side_a_current(o_side_a_current),
  .o_side_b_current(o_side_b_current), .o_corr_mode(o_corr_mode));

// ===== tb/lphc_host_model.sv
// host controller model driving the head pins
`timescale 1ns/1ps
module lphc_host_model (
  // clock
  input wire logic i_clk,
  // head pins
  output lphc_pkg::lphc_pins_t o_pins
);
  initial begin
    o_pins = 10'h00f;
  end
  task automatic half();
    repeat (4) @(posedge i_clk);
  endtask
  // one 80 ns shift clock period; lines are driven to the inverted value one cycle after the fall
  task automatic cyc(input logic [3:0] d);
    @(posedge i_clk);
    o_pins.print_data_line <= d;
    repeat (2) @(posedge i_clk);
    o_pins.print_shift_clock <= 1'b1;
    repeat (4) @(posedge i_clk);
    o_pins.print_shift_clock <= 1'b0;
    @(posedge i_clk);
    o_pins.print_data_line <= ~d;
  endtask
  task automatic latch(input logic v);
    @(posedge i_clk);
    o_pins.data_latch_ctl <= v;
    half();
  endtask
  task automatic fire(input logic [3:0] m);
    @(posedge i_clk);
    o_pins.led_fire_strobe_n <= ~m;
    repeat (8) @(posedge i_clk);
  endtask
endmodule

// ===== tb/test_led_print_head_correction_interface.sv
// self-checking bench of the correction head stage
`timescale 1ns/1ps
`include "lphc_map.svh"
module test_led_print_head_correction_interface;
  localparam int DOTS = 8;
  logic i_clk;
  logic i_rst_n;
  lphc_pkg::lphc_pins_t pins;
  lphc_pkg::lphc_pins_t fwd;
  logic [7:0] i_addr;
  logic [31:0] i_wdata;
  logic i_wr;
  logic i_rd;
  logic [31:0] o_rdata;
  logic [3:0] on_a;
  logic [3:0] on_b;
  logic [3:0][7:0] cur_a;
  logic [3:0][7:0] cur_b;
  logic corr;
  logic [3:0] code_tab [8];
  int err_total = 0;
  int checked = 0;

  lphc_host_model host (.i_clk(i_clk), .o_pins(pins));
  lphc_top #(.DOTS(DOTS)) dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_pins(pins), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_fwd_pins(fwd), .o_side_a_on(on_a),
    .o_side_b_on(on_b), .o_side_a_current(cur_a), .o_side_b_current(cur_b), .o_corr_mode(corr));

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", n, e, g);
      err_total++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    chk(n, e, o_rdata);
  endtask
  function automatic logic [7:0] exp_cur(input logic [3:0] c);
    if (c == 4'h8) return 8'h74;
    if (!c[3]) return 8'h64 + {3'h0, c, 1'b0};
    return 8'h64 - {3'h0, ~c + 4'h1, 1'b0};
  endfunction
  // line k carries dot 2k+p on rise p
  task automatic line(input logic [7:0] lit);
    for (int p = 0; p < 2; p++) begin
      host.cyc({lit[6+p], lit[4+p], lit[2+p], lit[p]});
    end
    host.latch(1'b1);
    host.latch(1'b0);
  endtask
  task automatic fire_chk(input logic [7:0] lit, input logic [3:0] m);
    logic [3:0] ea;
    logic [3:0] eb;
    logic [3:0][7:0] ca;
    logic [3:0][7:0] cb;
    for (int h = 0; h < 4; h++) begin
      ea[h] = lit[2*h] & m[h];
      eb[h] = lit[2*h+1] & m[h];
      ca[h] = ea[h] ? exp_cur(code_tab[2*h]) : 8'h00;
      cb[h] = eb[h] ? exp_cur(code_tab[2*h+1]) : 8'h00;
    end
    host.fire(m);
    @(negedge i_clk);
    chk("even side on", {28'h0, ea}, {28'h0, on_a});
    chk("odd side on", {28'h0, eb}, {28'h0, on_b});
    chk("even side current", ca, cur_a);
    chk("odd side current", cb, cur_b);
    chk("forwarded pins", {22'h0, pins}, {22'h0, fwd});
    host.fire(4'h0);
  endtask
  task automatic print_verdict();
    if (err_total == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge i_clk);
    err_total++;
    print_verdict();
  end

  initial begin
    i_rst_n = 1'b0;
    i_addr = 8'h00;
    i_wdata = 32'h0000_0000;
    i_wr = 1'b0;
    i_rd = 1'b0;
    repeat (8) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(negedge i_clk);
    chk("mode after reset", 32'h0000_0000, {31'h0, corr});
    rd_chk("ctrl", `LPHC_REG_CTRL, 32'h0000_0001);
    rd_chk("unmapped", 8'h20, 32'h0000_0000);
    for (int d = 0; d < 8; d++) begin
      code_tab[d] = d[3:0];
      wr(`LPHC_REG_MEM_ADDR, d);
      wr(`LPHC_REG_MEM_DATA, d);
    end
    // lock must shield stored codes
    wr(`LPHC_REG_CTRL, 32'h0000_0003);
    wr(`LPHC_REG_MEM_ADDR, 32'h0000_0003);
    wr(`LPHC_REG_MEM_DATA, 32'h0000_000f);
    rd_chk("locked code", `LPHC_REG_MEM_DATA, 32'h0000_0003);
    wr(`LPHC_REG_CTRL, 32'h0000_0001);
    line(8'hb6);
    for (int k = 0; k < 4; k++) begin
      fire_chk(8'hb6, 4'h1 << k);
    end
    host.latch(1'b1);
    for (int b = 0; b < 4; b++) begin
      host.cyc({3'h0, ~b[0]});
    end
    @(negedge i_clk);
    chk("mode before fifth fall", 32'h0000_0000, {31'h0, corr});
    host.cyc(4'h0);
    repeat (6) @(posedge i_clk);
    @(negedge i_clk);
    chk("mode after fifth fall", 32'h0000_0001, {31'h0, corr});
    for (int d = 0; d < 8; d++) begin
      code_tab[d] = 4'hf - d[3:0];
      host.cyc(code_tab[d]);
    end
    rd_chk("status", `LPHC_REG_STATUS, 32'h0000_00a1);
    host.latch(1'b0);
    // the falling latch needs five cycles through the pin filter and edge finder
    repeat (2) @(posedge i_clk);
    @(negedge i_clk);
    chk("mode after latch low", 32'h0000_0000, {31'h0, corr});
    wr(`LPHC_REG_MEM_ADDR, 32'h0000_0002);
    rd_chk("pin loaded code", `LPHC_REG_MEM_DATA, 32'h0000_000d);
    line(8'hff);
    fire_chk(8'hff, 4'hf);
    host.latch(1'b1);
    for (int b = 0; b < 4; b++) begin
      host.cyc({3'h0, b[0]});
    end
    host.cyc(4'h0);
    repeat (6) @(posedge i_clk);
    @(negedge i_clk);
    chk("mode after bad select", 32'h0000_0000, {31'h0, corr});
    rd_chk("bad selects", `LPHC_REG_BAD_CNT, 32'h0000_0001);
    rd_chk("select status", `LPHC_REG_STATUS, 32'h0000_0052);
    rd_chk("lines latched", `LPHC_REG_LINE_CNT, 32'h0000_0004);
    rd_chk("codes loaded", `LPHC_REG_CORR_CNT, 32'h0000_0008);
    host.latch(1'b0);
    // apply off: every lit dot back at the standard current
    wr(`LPHC_REG_CTRL, 32'h0000_0000);
    for (int d = 0; d < 8; d++) begin
      code_tab[d] = 4'h0;
    end
    fire_chk(8'hff, 4'hf);
    print_verdict();
  end
endmodule
